// File: verilog/accel_pkg.sv
// Constants, register map and shared types of the accelerometer readout block.
package accel_pkg;
    // ****************************************
    // Data widths and sizes
    // ****************************************
    localparam int RAW_W           = 12;
    localparam int OUT_W           = 10;
    localparam int SUM_W           = 16;
    localparam int ACC_W           = 19;
    localparam int AXES            = 3;
    localparam int FIFO_DEPTH      = 32;
    localparam int FIFO_W          = AXES * RAW_W;
    localparam int TRIM_WORDS      = 6;
    localparam int TRIM_GAIN_SHIFT = 8;
    // ****************************************
    // Scaling
    // ****************************************
    localparam int RAW_CNT_PER_G = 256;
    localparam int CNT_PER_G_2G  = 256;
    localparam int CNT_PER_G_4G  = 128;
    localparam int CNT_PER_G_8G  = 64;
    localparam int QUIET_RANGE_G = 4;
    localparam logic signed [SUM_W-1:0] QUIET_MAX =
        SUM_W'(QUIET_RANGE_G * RAW_CNT_PER_G - 1);
    localparam logic signed [SUM_W-1:0] QUIET_MIN = -QUIET_MAX - 16'sh0001;
    localparam logic signed [SUM_W-1:0] OUT_MAX   = SUM_W'((2 ** (OUT_W - 1)) - 1);
    localparam logic signed [SUM_W-1:0] OUT_MIN   = -OUT_MAX - 16'sh0001;
    localparam logic signed [SUM_W-1:0] ST_STIM   = 16'sh0020;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_X_HIGH   = 8'h00;
    localparam logic [7:0] ADDR_Y_HIGH   = 8'h02;
    localparam logic [7:0] ADDR_Z_HIGH   = 8'h04;
    localparam logic [7:0] ADDR_MODE     = 8'h06;
    localparam logic [7:0] ADDR_CTRL     = 8'h07;
    localparam logic [7:0] ADDR_CFG      = 8'h08;
    localparam logic [7:0] ADDR_OFS_FIRST = 8'h09;
    localparam logic [7:0] ADDR_OFS_LAST = 8'h0E;
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam int CTRL_FAST_BIT   = 1;
    localparam int CTRL_QUIET_BIT  = 2;
    localparam int CTRL_SLEEP_BIT  = 3;
    localparam int CFG_RANGE_LSB   = 0;
    localparam int CFG_OSR_LSB     = 2;
    localparam int CFG_SELFTEST_BIT = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_WAKE    = 2'h1;
    localparam logic [1:0] MODE_SLEEP   = 2'h2;
    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [1:0] {
        RANGE_2G = 2'h0,
        RANGE_4G = 2'h1,
        RANGE_8G = 2'h2
    } range_e;
    typedef enum logic [2:0] {
        PWR_OFF     = 3'h0,
        PWR_TRIM    = 3'h1,
        PWR_STANDBY = 3'h3,
        PWR_WAKE    = 3'h2,
        PWR_SLEEP   = 3'h6
    } pwr_e;
endpackage

// File: verilog/accel_readout.sv
// Sample FIFO and the accelerometer output, trim and mode logic.
// Notes on behaviour
// R1: Counts per g: 256, 128, 64 by range.
// R2: Each axis is signed 10-bit, two registers.
// R3: High register holds the upper eight bits.
// R4: Fast read steps through the high registers, then the mode register.
// R5: Fast read off exposes high and low registers.
// R6: 2 g range spans -512 to 511 counts.
// R7: 8 g range spans 64 counts per g.
// R8: Outputs start at 0x00, two's complement.
// R9: Off mode: everything reset, bus ignored.
// R10: Standby: no sampling, registers still accessible.
// R11: Active: sampling runs, bus stays available.
// R12: Active to standby keeps every register.
// R13: Standby to active clears the output subset.
// R14: Sleep and wake both report as active; the mode register reads MODE_SLEEP in sleep and MODE_WAKE in wake.
// R15: Self-test adds a fixed stimulus per axis.
// R16: Factory trim loads from NVM before data.
// R17: Six volatile user offset registers, two per axis.
// R18: Four oversampling settings average 1 to 8.
// R19: Quiet sampling is independent of oversampling.
// R20: All functions work in every range.
// R21: Quiet sampling limits range to 4 g.
// R22: Low register: two bits left-justified, rest zero.
// R23: High read freezes its low byte until read.
`timescale 1ns/1ps

// ****************************************
// Sample FIFO
// ****************************************
module sample_fifo
    import accel_pkg::*;
#(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        rdy;
    } fifo_s;

    fifo_s s_ff;
    fifo_s nxt_s;
    logic  push;
    logic  pop;

    assign in_ready  = s_ff.rdy;
    assign out_valid = (s_ff.cnt != '0);
    assign out_data  = s_ff.mem[s_ff.rp];

    always_comb begin
        nxt_s = s_ff;
        push  = in_valid && s_ff.rdy;
        pop   = out_valid && out_ready;
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data;
            nxt_s.wp           = (s_ff.wp == AW'(DEPTH - 1)) ? '0 : s_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_s.rp = (s_ff.rp == AW'(DEPTH - 1)) ? '0 : s_ff.rp + 1'b1;
        end
        nxt_s.cnt = s_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        if (flush) begin
            nxt_s.wp  = '0;
            nxt_s.rp  = '0;
            nxt_s.cnt = '0;
        end
        // Ready is registered so that the source sees a clean level.
        nxt_s.rdy = (nxt_s.cnt != (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule // sample_fifo

// ****************************************
// Readout and mode control
// ****************************************
module accel_readout
    import accel_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Supply monitor pin
    input  wire logic              pwr_ok,
    // Trim storage
    output logic                   nvm_rd,
    output logic [2:0]             nvm_addr,
    input  wire logic [7:0]        nvm_rdata,
    input  wire logic              nvm_ack,
    // Converter samples
    output logic                   sample_clk_en,
    input  wire logic              raw_valid,
    input  wire logic [RAW_W-1:0]  raw_x,
    input  wire logic [RAW_W-1:0]  raw_y,
    input  wire logic [RAW_W-1:0]  raw_z,
    output logic                   raw_ready,
    // Serial register access
    input  wire logic              reg_start,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    output logic                   reg_ack
);
    typedef struct packed {
        pwr_e                        pwr;
        logic [1:0]                  pok;
        logic                        nvm_rd;
        logic [2:0]                  nvm_addr;
        logic [TRIM_WORDS-1:0][7:0]  trim;
        logic [7:0]                  ctrl;
        logic [7:0]                  cfg;
        logic [5:0][7:0]             uofs;
        logic [AXES-1:0][OUT_W-1:0]  outv;
        logic [AXES-1:0][1:0]        shadow;
        logic [AXES-1:0]             hold;
        logic [2:0]                  osc;
        logic [AXES-1:0][ACC_W-1:0]  acc;
        logic [7:0]                  ptr;
        logic [7:0]                  rdata;
        logic                        ack;
        logic                        flush;
        logic                        clk_en;
    } state_s;

    function automatic state_s rst_state();
        state_s r;
        r      = '0;
        r.pwr  = PWR_OFF;
        r.ctrl = CTRL_RST;
        r.cfg  = CFG_RST;
        return r;
    endfunction

    localparam state_s ST_RST = rst_state();

    function automatic logic [1:0] range_shift(input logic [1:0] rng);
        case (rng)
            RANGE_2G: return 2'($clog2(RAW_CNT_PER_G / CNT_PER_G_2G));
            RANGE_4G: return 2'($clog2(RAW_CNT_PER_G / CNT_PER_G_4G));
            default:  return 2'($clog2(RAW_CNT_PER_G / CNT_PER_G_8G));
        endcase
    endfunction

    function automatic logic [2:0] osr_last(input logic [1:0] osr);
        return 3'((1 << osr) - 1);
    endfunction

    function automatic logic signed [SUM_W-1:0] trim_val(
        input logic signed [RAW_W-1:0] r,
        input logic        [7:0]       g,
        input logic        [7:0]       o,
        input logic        [OUT_W-1:0] u,
        input logic                    st
    );
        logic signed [RAW_W+7:0] p;
        logic signed [SUM_W-1:0] t;
        p = r * $signed(g);
        t = SUM_W'(r) + SUM_W'(p >>> TRIM_GAIN_SHIFT) + SUM_W'($signed(o))
            + SUM_W'($signed(u));
        if (st) begin
            t = t + ST_STIM; // R15
        end
        return t;
    endfunction

    function automatic logic [OUT_W-1:0] scale_sat(
        input logic signed [SUM_W-1:0] v,
        input logic        [1:0]       rng,
        input logic                    quiet
    );
        logic signed [SUM_W-1:0] t;
        t = v;
        if (quiet && t > QUIET_MAX) begin
            t = QUIET_MAX; // R21
        end else if (quiet && t < QUIET_MIN) begin
            t = QUIET_MIN; // R21
        end
        // Clamping before the shift keeps the limit at 4 g in the 4 g and 8 g ranges; 2 g saturates at 511 first.
        t = t >>> range_shift(rng); // R1 R20
        if (t > OUT_MAX) begin
            t = OUT_MAX; // R6 R7
        end else if (t < OUT_MIN) begin
            t = OUT_MIN; // R6 R7
        end
        return t[OUT_W-1:0];
    endfunction

    function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic fast);
        if (fast && p == ADDR_X_HIGH) begin
            return ADDR_Y_HIGH; // R4
        end else if (fast && p == ADDR_Y_HIGH) begin
            return ADDR_Z_HIGH; // R4
        end else if (fast && p == ADDR_Z_HIGH) begin
            return ADDR_MODE; // R4
        end else if (p >= ADDR_OFS_LAST) begin
            return ADDR_X_HIGH;
        end
        return p + 8'h01; // R5
    endfunction

    state_s             s_ff;
    state_s             nxt_s;
    logic [FIFO_W-1:0]  fifo_data;
    logic               fifo_valid;
    logic               drain;

    assign nvm_rd        = s_ff.nvm_rd;
    assign nvm_addr      = s_ff.nvm_addr;
    assign sample_clk_en = s_ff.clk_en;
    assign reg_rdata     = s_ff.rdata;
    assign reg_ack       = s_ff.ack;
    // Samples leave the FIFO only while active; in standby it fills and stalls the source.
    assign drain = s_ff.clk_en && !s_ff.flush;

    sample_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .flush     (s_ff.flush),
        .in_valid  (raw_valid),
        .in_data   ({raw_z, raw_y, raw_x}),
        .in_ready  (raw_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (drain)
    );

    always_comb begin
        logic signed [SUM_W-1:0] v;
        logic signed [ACC_W-1:0] a;
        logic                    done;
        logic                    awake;
        logic [1:0]              ax;
        logic [1:0]              osr;
        v     = '0;
        a     = '0;
        done  = 1'b0;
        awake = (s_ff.pwr == PWR_WAKE) || (s_ff.pwr == PWR_SLEEP);
        ax    = s_ff.ptr[2:1];
        osr   = s_ff.cfg[CFG_OSR_LSB +: 2];
        nxt_s = s_ff;
        nxt_s.pok    = {s_ff.pok[0], pwr_ok};
        nxt_s.ack    = 1'b0;
        nxt_s.nvm_rd = 1'b0;
        nxt_s.flush  = 1'b0;

        case (s_ff.pwr)
            PWR_OFF: begin
                nxt_s.pwr    = PWR_TRIM; // R16
                nxt_s.nvm_rd = 1'b1;
            end
            PWR_TRIM: begin
                if (nvm_ack) begin
                    nxt_s.trim[s_ff.nvm_addr] = nvm_rdata; // R16
                    if (s_ff.nvm_addr == 3'(TRIM_WORDS - 1)) begin
                        nxt_s.pwr = PWR_STANDBY;
                    end else begin
                        nxt_s.nvm_addr = s_ff.nvm_addr + 3'h1;
                        nxt_s.nvm_rd   = 1'b1;
                    end
                end
            end
            PWR_STANDBY: begin
                if (s_ff.ctrl[CTRL_ACTIVE_BIT]) begin
                    nxt_s.pwr   = s_ff.ctrl[CTRL_SLEEP_BIT] ? PWR_SLEEP : PWR_WAKE; // R11
                    nxt_s.outv  = '0; // R13
                    nxt_s.hold  = '0; // R13
                    nxt_s.acc   = '0; // R13
                    nxt_s.osc   = '0; // R13
                    nxt_s.flush = 1'b1; // R13
                end
            end
            default: begin
                if (!s_ff.ctrl[CTRL_ACTIVE_BIT]) begin
                    nxt_s.pwr = PWR_STANDBY; // R12
                end else begin
                    nxt_s.pwr = s_ff.ctrl[CTRL_SLEEP_BIT] ? PWR_SLEEP : PWR_WAKE; // R14
                end
            end
        endcase
        nxt_s.clk_en = (nxt_s.pwr == PWR_WAKE) || (nxt_s.pwr == PWR_SLEEP); // R10 R11

        // Trimmed, oversampled and scaled sample path.
        if (fifo_valid && drain) begin
            done = (s_ff.osc == osr_last(osr)); // R18
            for (int i = 0; i < AXES; i++) begin
                v = trim_val($signed(fifo_data[i*RAW_W +: RAW_W]), s_ff.trim[i],
                             s_ff.trim[i+AXES], {s_ff.uofs[2*i], s_ff.uofs[2*i+1][7:6]},
                             s_ff.cfg[CFG_SELFTEST_BIT]); // R16 R17
                a = $signed(s_ff.acc[i]) + ACC_W'(v);
                if (done) begin
                    nxt_s.acc[i]  = '0;
                    nxt_s.outv[i] = scale_sat(SUM_W'(a >>> osr), s_ff.cfg[CFG_RANGE_LSB +: 2],
                                              s_ff.ctrl[CTRL_QUIET_BIT]); // R2 R19
                end else begin
                    nxt_s.acc[i] = a;
                end
            end
            nxt_s.osc = done ? 3'h0 : s_ff.osc + 3'h1;
        end

        // Register access through the auto-incrementing pointer.
        if (s_ff.pwr == PWR_STANDBY || awake) begin
            if (reg_start) begin
                nxt_s.ptr = reg_addr;
                nxt_s.ack = 1'b1;
            end else if (reg_wr) begin
                nxt_s.ack = 1'b1;
                nxt_s.ptr = next_ptr(s_ff.ptr, s_ff.ctrl[CTRL_FAST_BIT]);
                if (s_ff.ptr == ADDR_CTRL) begin
                    nxt_s.ctrl = reg_wdata;
                end else if (s_ff.ptr == ADDR_CFG) begin
                    nxt_s.cfg = reg_wdata;
                end else if (s_ff.ptr >= ADDR_OFS_FIRST && s_ff.ptr <= ADDR_OFS_LAST) begin
                    nxt_s.uofs[3'(s_ff.ptr - ADDR_OFS_FIRST)] = reg_wdata; // R17
                end
            end else if (reg_rd) begin
                nxt_s.ack = 1'b1;
                nxt_s.ptr = next_ptr(s_ff.ptr, s_ff.ctrl[CTRL_FAST_BIT]); // R4 R5
                if (s_ff.ptr < ADDR_MODE && !s_ff.ptr[0]) begin
                    nxt_s.rdata      = s_ff.outv[ax][OUT_W-1:2]; // R3 R8
                    nxt_s.hold[ax]   = 1'b1; // R23
                    nxt_s.shadow[ax] = s_ff.outv[ax][1:0]; // R23
                end else if (s_ff.ptr < ADDR_MODE) begin
                    nxt_s.rdata    = {(s_ff.hold[ax] ? s_ff.shadow[ax]
                                                     : s_ff.outv[ax][1:0]), 6'h00}; // R22 R23
                    nxt_s.hold[ax] = 1'b0; // R23
                end else if (s_ff.ptr == ADDR_MODE) begin
                    nxt_s.rdata = {6'h00, (s_ff.pwr == PWR_SLEEP) ? MODE_SLEEP
                                        : (awake ? MODE_WAKE : MODE_STANDBY)}; // R14
                end else if (s_ff.ptr == ADDR_CTRL) begin
                    nxt_s.rdata = s_ff.ctrl;
                end else if (s_ff.ptr == ADDR_CFG) begin
                    nxt_s.rdata = s_ff.cfg;
                end else if (s_ff.ptr >= ADDR_OFS_FIRST && s_ff.ptr <= ADDR_OFS_LAST) begin
                    nxt_s.rdata = s_ff.uofs[3'(s_ff.ptr - ADDR_OFS_FIRST)];
                end else begin
                    nxt_s.rdata = 8'h00;
                end
            end
        end

        // Losing supply wipes every register, so volatile offsets are gone too.
        if (!s_ff.pok[1]) begin
            nxt_s     = ST_RST; // R9
            nxt_s.pok = {s_ff.pok[0], pwr_ok};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= ST_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule // accel_readout

// File: test/accel_readout_assertions.sv
// Port checks of the readout block and their binding.
`timescale 1ns/1ps
module accel_readout_chk (
    // Clock, reset and supply
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       pwr_ok,
    // Trim storage
    input wire logic       nvm_rd,
    input wire logic [2:0] nvm_addr,
    // Samples
    input wire logic       sample_clk_en,
    input wire logic       raw_ready,
    // Register access
    input wire logic       reg_start,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_ack
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ****************************************
    // Assertions
    // ****************************************
    chk_ack_cause: assert property (reg_ack |-> $past(reg_start || reg_wr || reg_rd))
        else $error("acknowledge without a request");
    chk_off_silent: assert property (!pwr_ok [*5] |-> !reg_ack)
        else $error("acknowledge while powered off");
    chk_gate_off: assert property (!pwr_ok [*5] |-> !sample_clk_en)
        else $error("sample clock enabled while powered off");
    chk_nvm_pulse: assert property (nvm_rd |=> !nvm_rd)
        else $error("trim read longer than one cycle");
    chk_nvm_addr: assert property (nvm_rd |-> nvm_addr <= 3'h5)
        else $error("trim word index out of range");
    chk_rdata_hold: assert property ($changed(reg_rdata) && pwr_ok && $past(pwr_ok, 4)
        |-> reg_ack)
        else $error("read data changed without a read");
    chk_gate_rise: assert property ($rose(sample_clk_en) |-> $past(reg_ack))
        else $error("sample clock enabled without a control write");
    chk_trim_quiet: assert property (nvm_rd |-> !reg_ack && !sample_clk_en)
        else $error("bus or sampling active during trim load");
    // ****************************************
    // Coverage
    // ****************************************
    cov_active: cover property ($rose(sample_clk_en));
    cov_full: cover property (sample_clk_en == 1'b0 && raw_ready == 1'b0);
    cov_fast: cover property (reg_start && reg_addr == 8'h00 ##2 reg_rd);
endmodule // accel_readout_chk

bind accel_readout accel_readout_chk u_chk (
    .clk(clk), .rstn(rstn), .pwr_ok(pwr_ok), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
    .sample_clk_en(sample_clk_en), .raw_ready(raw_ready), .reg_start(reg_start),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack)
);

// File: test/trim_store_model.sv
// Trim storage model that answers word reads of the readout block.
`timescale 1ns/1ps
module trim_store_model #(
    parameter logic [7:0] GAIN = 8'h10,
    parameter logic [7:0] OFS  = 8'h03,
    parameter int         SLOW = 3
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Word read port
    input  wire logic       nvm_rd,
    input  wire logic [2:0] nvm_addr,
    output logic      [7:0] nvm_rdata,
    output logic            nvm_ack
);
    int         cnt;
    logic [2:0] addr_q;
    // Data toggles between answers so a stale word never passes as fresh.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt       <= 0;
            addr_q    <= 3'h0;
            nvm_ack   <= 1'b0;
            nvm_rdata <= 8'hA5;
        end else begin
            nvm_ack   <= 1'b0;
            nvm_rdata <= ~nvm_rdata;
            if (nvm_rd) begin
                cnt    <= nvm_addr[0] ? SLOW : 1;
                addr_q <= nvm_addr;
            end else if (cnt == 1) begin
                cnt       <= 0;
                nvm_ack   <= 1'b1;
                nvm_rdata <= (addr_q < 3'h3) ? GAIN : OFS;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // trim_store_model

// File: test/tb_accel_output_and_mode_control.sv
// Self-checking testbench of the readout block.
`timescale 1ns/1ps
module tb_accel_output_and_mode_control;
    import accel_pkg::*;
    logic             clk, rstn, pwr_ok, nvm_rd, nvm_ack, sample_clk_en;
    logic [2:0]       nvm_addr;
    logic [7:0]       nvm_rdata, reg_addr, reg_wdata, reg_rdata, q, h, l;
    logic             raw_valid, raw_ready, reg_start, reg_wr, reg_rd, reg_ack, k;
    logic [RAW_W-1:0] raw_x, raw_y, raw_z;
    logic [7:0]       eh[3], el[3];
    int               fail_count, cmp_count, r[3], r2[3], uofs[3];
    int               cpg[3] = '{CNT_PER_G_2G, CNT_PER_G_4G, CNT_PER_G_8G};

    accel_readout dut (
        .clk(clk), .rstn(rstn), .pwr_ok(pwr_ok), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
        .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack), .sample_clk_en(sample_clk_en),
        .raw_valid(raw_valid), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
        .raw_ready(raw_ready), .reg_start(reg_start), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
    trim_store_model u_trim (.clk(clk), .rstn(rstn), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
        .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ****************************************
    // Tasks and expectations
    // ****************************************
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    // One bus transfer: 0 start, 1 write, 2 read; the answer is taken one cycle later.
    task automatic bus(input int t, input logic [7:0] d, output logic [7:0] rq, output logic a);
        reg_start = (t == 0);
        reg_wr    = (t == 1);
        reg_rd    = (t == 2);
        if (t == 0) reg_addr = d;
        else reg_wdata = d;
        tick();
        rq = reg_rdata;
        a  = reg_ack;
        {reg_start, reg_wr, reg_rd} = 3'b000;
        tick();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(0, a, q, k);
        bus(1, d, q, k);
        chk_bit(k, 1'b1);
    endtask
    task automatic rd2(input logic [7:0] a, output logic [7:0] hi, output logic [7:0] lo);
        bus(0, a, hi, k);
        bus(2, 8'h00, hi, k);
        bus(2, 8'h00, lo, k);
    endtask
    task automatic wait_trim();
        for (int n = 0; n <= 60; n++) begin
            if (n == 60) begin
                fail_count++;
                report_and_stop();
            end
            bus(0, ADDR_CTRL, q, k);
            if (k === 1'b1) break;
        end
    endtask
    task automatic push(input int v[3]);
        raw_x     = RAW_W'(v[0]);
        raw_y     = RAW_W'(v[1]);
        raw_z     = RAW_W'(v[2]);
        raw_valid = 1'b1;
        for (int n = 0; raw_ready !== 1'b1; n++) begin
            if (n == 100) begin
                fail_count++;
                report_and_stop();
            end
            tick();
        end
        tick();
        raw_valid = 1'b0;
        raw_x     = RAW_W'($urandom);
        tick();
    endtask
    function automatic int rnd();
        return int'($signed(RAW_W'($urandom)));
    endfunction
    function automatic logic [9:0] expect_axis(int v, int ax, int st, int rng, int qt);
        v = v + ((v * 16) >>> 8) + 3 + uofs[ax] + (st ? int'(ST_STIM) : 0);
        if (qt != 0) v = (v > int'(QUIET_MAX)) ? int'(QUIET_MAX) : v;
        if (qt != 0) v = (v < int'(QUIET_MIN)) ? int'(QUIET_MIN) : v;
        v = v >>> $clog2(RAW_CNT_PER_G / cpg[rng]);
        v = (v > int'(OUT_MAX)) ? int'(OUT_MAX) : (v < int'(OUT_MIN)) ? int'(OUT_MIN) : v;
        return v[9:0];
    endfunction
    task automatic check_axes(input int v[3], input int st, input int rng, input int qt);
        logic [9:0] e;
        tick(3);
        for (int i = 0; i < AXES; i++) begin
            e     = expect_axis(v[i], i, st, rng, qt);
            eh[i] = e[9:2];
            el[i] = {e[1:0], 6'h00};
            rd2(8'(2 * i), h, l);
            chk_byte(h, eh[i]);
            chk_byte(l, el[i]);
        end
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rstn, pwr_ok, raw_valid, reg_start, reg_wr, reg_rd} = 6'h00;
        {raw_x, raw_y, raw_z, reg_addr, reg_wdata} = '0;
        uofs = '{1, 0, 0};
        void'($urandom(24));
        tick(2);
        rstn   = 1'b1;
        pwr_ok = 1'b1;
        tick(4);
        bus(0, ADDR_CTRL, q, k);
        chk_bit(k, 1'b0);
        wait_trim();
        rd2(ADDR_MODE, h, l);
        chk_byte(h, {6'h00, MODE_STANDBY});
        chk_byte(l, CTRL_RST);
        rd2(ADDR_CFG, h, l);
        chk_byte(h, CFG_RST);
        chk_byte(l, 8'h00);
        rd2(8'h30, h, l);
        chk_byte(h, 8'h00);
        wr(ADDR_X_HIGH, 8'h5A);
        rd2(ADDR_X_HIGH, h, l);
        chk_byte(h, 8'h00);
        for (int i = 0; i < FIFO_DEPTH; i++) push('{rnd(), rnd(), rnd()});
        chk_bit(raw_ready, 1'b0);
        chk_bit(sample_clk_en, 1'b0);
        wr(ADDR_OFS_FIRST + 8'h01, 8'h40);
        wr(ADDR_CTRL, 8'h01);
        tick(2);
        chk_bit(sample_clk_en, 1'b1);
        chk_bit(raw_ready, 1'b1);
        check_axes('{-3, -2, -2}, 0, 0, 0);
        for (int j = 0; j < 6; j++) begin
            r = (j == 0) ? '{2047, -2048, 0} : '{rnd(), rnd(), rnd()};
            wr(ADDR_CFG, 8'((j % 2) * 16 + j / 2));
            push(r);
            check_axes(r, j % 2, j / 2, 0);
        end
        wr(ADDR_CTRL, 8'h05);
        push('{2047, -2048, 100});
        check_axes('{2047, -2048, 100}, 1, 2, 1);
        wr(ADDR_CFG, 8'h04);
        r  = '{rnd() & -32, rnd() & -32, rnd() & -32};
        r2 = '{rnd() & -32, rnd() & -32, rnd() & -32};
        push(r);
        push(r2);
        for (int i = 0; i < AXES; i++) r[i] = (r[i] + r2[i]) >>> 1;
        check_axes(r, 0, 0, 1);
        wr(ADDR_CTRL, 8'h09);
        rd2(ADDR_MODE, h, l);
        chk_byte(h, {6'h00, MODE_SLEEP});
        chk_bit(sample_clk_en, 1'b1);
        wr(ADDR_CTRL, 8'h03);
        bus(0, ADDR_X_HIGH, q, k);
        for (int i = 0; i < 4; i++) begin
            bus(2, 8'h00, q, k);
            chk_byte(q, (i < 3) ? eh[i] : {6'h00, MODE_WAKE});
        end
        wr(ADDR_CTRL, 8'h01);
        rd2(ADDR_X_HIGH, h, l);
        chk_byte(l, el[0]);
        wr(ADDR_CFG, 8'h03);
        bus(0, ADDR_X_HIGH, q, k);
        bus(2, 8'h00, q, k);
        r   = '{rnd() | 1, rnd(), rnd()};
        push(r);
        tick(3);
        bus(2, 8'h00, q, k);
        chk_byte(q, el[0]);
        check_axes(r, 0, 2, 0);
        wr(ADDR_CTRL, 8'h00);
        rd2(ADDR_X_HIGH, h, l);
        chk_byte(h, eh[0]);
        chk_byte(l, el[0]);
        pwr_ok = 1'b0;
        tick(6);
        bus(0, ADDR_CTRL, q, k);
        chk_bit(k, 1'b0);
        pwr_ok = 1'b1;
        wait_trim();
        rd2(ADDR_CFG, h, l);
        chk_byte(h, CFG_RST);
        report_and_stop();
    end
endmodule // tb_accel_output_and_mode_control
